// >>> hdl/ccp_top.sv
// Cell voltage supervision and charge stage control with Avalon-MM registers
// Notes on behaviour
// - Over-voltage enabled, cell above max: protect
// - Limit violated while charging: abort, error code
// - Violation logs event, bumps statistics counter
// - Fully-charged voltage is charging target
// - Max minus min above disbalance: flag
// - Early balance: main stage, disbalance, threshold
// - Plain charger: balance down, recharge in range
// - Ended with charger: restart below restart voltage
// - Min cell below pre-threshold: pre-charge current
// - Above pre-threshold: main stage, nominal current
// - Very low pre-threshold disables pre-charge
// - Under-voltage enabled, cell below min: protect
// - Fast select picks fast, else slow
// - Full voltage reached: ramp commandable current down
// - Balanced and current at finish: finished
// - Finish and pre currents percent of nominal
// - Full is 100%, empty is 0% reference
module ccp_top (
	// Clock, reset, enable
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Avalon-MM slave
	input wire logic [7:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// Cell measurements, same clock domain
	input wire logic [ccp_pkg::NCELL*ccp_pkg::VW-1:0] cell_mv_i,
	// Charger side
	input wire logic charger_present_i,
	input wire logic fast_charge_select_function_i,
	output ccp_pkg::ccp_chg_t charger_o,
	output logic balance_o,
	output logic charge_done_o,
	// Protection and references
	output logic protection_output_function_o,
	output logic [ccp_pkg::VW-1:0] soc_full_ref_o,
	output logic [ccp_pkg::VW-1:0] soc_empty_ref_o,
	output logic irq_o
);
	// Configuration storage
	logic [2:0] ctrl_q;
	logic [ccp_pkg::VW-1:0] vmax_q, vfull_q, disb_q, ebal_q, brng_q, vrst_q, vpre_q, vempty_q, vmin_q;
	logic [ccp_pkg::IW-1:0] ifast_q, islow_q;
	logic [7:0] pfin_q, ppre_q;
	logic [ccp_pkg::IRQ_W-1:0] irq_st_q, irq_mask_q, irq_ev;
	logic [15:0] ov_cnt_q, uv_cnt_q;
	logic [3:0] err_q;
	ccp_pkg::ccp_stage_t stage_q;
	logic [ccp_pkg::IW-1:0] ireq_q;
	logic [15:0] ramp_cnt_q;
	logic ov_prev_q, uv_prev_q, disb_prev_q;
	logic [31:0] rdata_q;
	logic ack_q;
	logic [ccp_pkg::VW-1:0] vhi, vlo;
	logic [31:0] wmask;
	logic wr_go, rd_go;

	// Byte lane mask
	always_comb begin
		for (int b = 0; b < 4; b++) begin
			wmask[b*8 +: 8] = {8{avs_byteenable_i[b]}};
		end
	end

	// One wait cycle per access; a write lands at the answering edge only
	assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~(ack_q & ce_i);
	assign wr_go = ce_i & avs_write_i & ack_q;
	assign rd_go = ce_i & avs_read_i & ~ack_q;

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
		end else if (ce_i) begin
			ack_q <= (avs_read_i | avs_write_i) & ~ack_q;
		end
	end

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [31:0] m);
		merge = (old & ~m) | (nw & m);
	endfunction

	// Configuration writes; every compare uses these stored values
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			ctrl_q <= 3'h3;
			vmax_q <= ccp_pkg::RST_VMAX;
			vfull_q <= ccp_pkg::RST_VFULL;
			disb_q <= ccp_pkg::RST_DISB;
			ebal_q <= ccp_pkg::RST_EBAL;
			brng_q <= ccp_pkg::RST_BRNG;
			vrst_q <= ccp_pkg::RST_VRST;
			vpre_q <= ccp_pkg::RST_VPRE;
			vempty_q <= ccp_pkg::RST_VEMPTY;
			vmin_q <= ccp_pkg::RST_VMIN;
			ifast_q <= ccp_pkg::RST_IFAST;
			islow_q <= ccp_pkg::RST_ISLOW;
			pfin_q <= ccp_pkg::RST_PFIN;
			ppre_q <= ccp_pkg::RST_PPRE;
			irq_mask_q <= '0;
		end else if (wr_go) begin
			unique case (avs_address_i)
				ccp_pkg::OFS_CTRL: ctrl_q <= 3'(merge({29'h0, ctrl_q}, avs_writedata_i, wmask));
				ccp_pkg::OFS_VMAX: vmax_q <= 16'(merge({16'h0, vmax_q}, avs_writedata_i, wmask));
				ccp_pkg::OFS_VFULL: vfull_q <= 16'(merge({16'h0, vfull_q}, avs_writedata_i, wmask));
				ccp_pkg::OFS_DISB: disb_q <= 16'(merge({16'h0, disb_q}, avs_writedata_i, wmask));
				ccp_pkg::OFS_EBAL: ebal_q <= 16'(merge({16'h0, ebal_q}, avs_writedata_i, wmask));
				ccp_pkg::OFS_BRNG: brng_q <= 16'(merge({16'h0, brng_q}, avs_writedata_i, wmask));
				ccp_pkg::OFS_VRST: vrst_q <= 16'(merge({16'h0, vrst_q}, avs_writedata_i, wmask));
				ccp_pkg::OFS_VPRE: vpre_q <= 16'(merge({16'h0, vpre_q}, avs_writedata_i, wmask));
				ccp_pkg::OFS_VEMPTY: vempty_q <= 16'(merge({16'h0, vempty_q}, avs_writedata_i, wmask));
				ccp_pkg::OFS_VMIN: vmin_q <= 16'(merge({16'h0, vmin_q}, avs_writedata_i, wmask));
				ccp_pkg::OFS_IFAST: ifast_q <= 16'(merge({16'h0, ifast_q}, avs_writedata_i, wmask));
				ccp_pkg::OFS_ISLOW: islow_q <= 16'(merge({16'h0, islow_q}, avs_writedata_i, wmask));
				ccp_pkg::OFS_PFIN: pfin_q <= 8'(merge({24'h0, pfin_q}, avs_writedata_i, wmask));
				ccp_pkg::OFS_PPRE: ppre_q <= 8'(merge({24'h0, ppre_q}, avs_writedata_i, wmask));
				ccp_pkg::OFS_IRQ_MASK: irq_mask_q <= ccp_pkg::IRQ_W'(merge({27'h0, irq_mask_q}, avs_writedata_i, wmask));
				default: ;
			endcase
		end
	end

	// Highest and lowest cell, one generate-free loop over the vector
	always_comb begin
		vhi = '0;
		vlo = '1;
		for (int c = 0; c < ccp_pkg::NCELL; c++) begin
			if (cell_mv_i[c*ccp_pkg::VW +: ccp_pkg::VW] > vhi) vhi = cell_mv_i[c*ccp_pkg::VW +: ccp_pkg::VW];
			if (cell_mv_i[c*ccp_pkg::VW +: ccp_pkg::VW] < vlo) vlo = cell_mv_i[c*ccp_pkg::VW +: ccp_pkg::VW];
		end
	end

	// Limit checks
	logic ov_hit, uv_hit, disb_hit, charging;
	assign ov_hit = ctrl_q[ccp_pkg::CTRL_OV_EN] & (vhi > vmax_q);
	assign uv_hit = ctrl_q[ccp_pkg::CTRL_UV_EN] & (vlo < vmin_q);
	assign disb_hit = (vhi - vlo) > disb_q;
	assign charging = (stage_q != ccp_pkg::CCP_IDLE) && (stage_q != ccp_pkg::CCP_DONE);

	// Protection output held while a limit is violated
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			protection_output_function_o <= 1'b0;
			balance_o <= 1'b0;
		end else if (ce_i) begin
			protection_output_function_o <= ov_hit | uv_hit;
			balance_o <= disb_hit;
		end
	end

	// Nominal, pre-charge and finish currents as percent of nominal
	logic [ccp_pkg::IW-1:0] inom, ipre, ifin;
	logic [23:0] ipre_w, ifin_w;
	assign inom = fast_charge_select_function_i ? ifast_q : islow_q;
	assign ipre_w = (inom * ppre_q) / {16'h0, ccp_pkg::PCT_FULL};
	assign ifin_w = (inom * pfin_q) / {16'h0, ccp_pkg::PCT_FULL};
	assign ipre = ipre_w[ccp_pkg::IW-1:0];
	assign ifin = ifin_w[ccp_pkg::IW-1:0];

	// Event edges and statistics counters
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			ov_prev_q <= 1'b0;
			uv_prev_q <= 1'b0;
			disb_prev_q <= 1'b0;
			ov_cnt_q <= '0;
			uv_cnt_q <= '0;
		end else if (ce_i) begin
			ov_prev_q <= ov_hit;
			uv_prev_q <= uv_hit;
			disb_prev_q <= disb_hit;
			if (ov_hit & ~ov_prev_q) ov_cnt_q <= ov_cnt_q + 16'h0001;
			if (uv_hit & ~uv_prev_q) uv_cnt_q <= uv_cnt_q + 16'h0001;
		end
	end

	// Charge stage machine
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			stage_q <= ccp_pkg::CCP_IDLE;
			ireq_q <= '0;
			ramp_cnt_q <= '0;
			err_q <= ccp_pkg::ERR_NONE;
		end else if (ce_i) begin
			if (charging && (ov_hit || uv_hit)) begin
				stage_q <= ccp_pkg::CCP_DONE;
				ireq_q <= '0;
				err_q <= ov_hit ? ccp_pkg::ERR_OV : ccp_pkg::ERR_UV;
			end else if (!charger_present_i) begin
				stage_q <= ccp_pkg::CCP_IDLE;
				ireq_q <= '0;
			end else begin
				unique case (stage_q)
					ccp_pkg::CCP_IDLE: begin
						// Pre-charge skipped when the threshold sits below every cell
						if (!(ov_hit || uv_hit)) begin
							stage_q <= (vlo < vpre_q) ? ccp_pkg::CCP_PRE : ccp_pkg::CCP_MAIN;
							err_q <= ccp_pkg::ERR_NONE;
						end
					end
					ccp_pkg::CCP_PRE: begin
						ireq_q <= ipre;
						if (vlo > vpre_q) stage_q <= ccp_pkg::CCP_MAIN;
					end
					ccp_pkg::CCP_MAIN, ccp_pkg::CCP_EARLY: begin
						ireq_q <= inom;
						stage_q <= (disb_hit && vhi > ebal_q) ? ccp_pkg::CCP_EARLY : ccp_pkg::CCP_MAIN;
						if (vhi >= vfull_q) begin
							stage_q <= ctrl_q[ccp_pkg::CTRL_CMD_CHG] ? ccp_pkg::CCP_RAMP : ccp_pkg::CCP_BAL_DOWN;
						end
					end
					ccp_pkg::CCP_RAMP: begin
						// Slow step so the cells settle between reductions
						ramp_cnt_q <= (ramp_cnt_q == ccp_pkg::RAMP_DIV) ? 16'h0000 : ramp_cnt_q + 16'h0001;
						if (ramp_cnt_q == ccp_pkg::RAMP_DIV && vhi >= vfull_q && ireq_q > ifin) begin
							ireq_q <= ((ireq_q - ccp_pkg::RAMP_STEP) < ifin) ? ifin : ireq_q - ccp_pkg::RAMP_STEP;
						end
						if (!disb_hit && ireq_q <= ifin) stage_q <= ccp_pkg::CCP_DONE;
					end
					ccp_pkg::CCP_BAL_DOWN: begin
						ireq_q <= '0;
						if (!disb_hit) stage_q <= ccp_pkg::CCP_DONE;
						else if (vhi < vfull_q - brng_q) stage_q <= ccp_pkg::CCP_BAL_UP;
					end
					ccp_pkg::CCP_BAL_UP: begin
						ireq_q <= inom;
						if (vhi >= vfull_q) stage_q <= ccp_pkg::CCP_BAL_DOWN;
					end
					ccp_pkg::CCP_DONE: begin
						ireq_q <= '0;
						if (vlo < vrst_q && !(ov_hit || uv_hit)) stage_q <= ccp_pkg::CCP_IDLE;
					end
				endcase
			end
		end
	end

	// Events into sticky status, set beats write-one-clear
	assign irq_ev[ccp_pkg::IRQ_OV] = ov_hit & ~ov_prev_q;
	assign irq_ev[ccp_pkg::IRQ_UV] = uv_hit & ~uv_prev_q;
	assign irq_ev[ccp_pkg::IRQ_ABORT] = ce_i & charging & (ov_hit | uv_hit);
	assign irq_ev[ccp_pkg::IRQ_FINISH] = ce_i & charging & charger_present_i & ~(ov_hit | uv_hit)
		& (stage_q == ccp_pkg::CCP_RAMP) & ~disb_hit & (ireq_q <= ifin);
	assign irq_ev[ccp_pkg::IRQ_DISB] = disb_hit & ~disb_prev_q;

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			irq_st_q <= '0;
		end else if (ce_i) begin
			if (wr_go && avs_address_i == ccp_pkg::OFS_IRQ_ST && avs_byteenable_i[0]) begin
				irq_st_q <= (irq_st_q & ~avs_writedata_i[ccp_pkg::IRQ_W-1:0]) | irq_ev;
			end else begin
				irq_st_q <= irq_st_q | irq_ev;
			end
		end
	end
	assign irq_o = |(irq_st_q & irq_mask_q);

	// Read data, captured at the first edge of the access
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			rdata_q <= '0;
		end else if (rd_go) begin
			unique case (avs_address_i)
				ccp_pkg::OFS_CTRL: rdata_q <= {29'h0, ctrl_q};
				ccp_pkg::OFS_VMAX: rdata_q <= {16'h0, vmax_q};
				ccp_pkg::OFS_VFULL: rdata_q <= {16'h0, vfull_q};
				ccp_pkg::OFS_DISB: rdata_q <= {16'h0, disb_q};
				ccp_pkg::OFS_EBAL: rdata_q <= {16'h0, ebal_q};
				ccp_pkg::OFS_BRNG: rdata_q <= {16'h0, brng_q};
				ccp_pkg::OFS_VRST: rdata_q <= {16'h0, vrst_q};
				ccp_pkg::OFS_VPRE: rdata_q <= {16'h0, vpre_q};
				ccp_pkg::OFS_VEMPTY: rdata_q <= {16'h0, vempty_q};
				ccp_pkg::OFS_VMIN: rdata_q <= {16'h0, vmin_q};
				ccp_pkg::OFS_IFAST: rdata_q <= {16'h0, ifast_q};
				ccp_pkg::OFS_ISLOW: rdata_q <= {16'h0, islow_q};
				ccp_pkg::OFS_PFIN: rdata_q <= {24'h0, pfin_q};
				ccp_pkg::OFS_PPRE: rdata_q <= {24'h0, ppre_q};
				ccp_pkg::OFS_STATUS: rdata_q <= {11'h0, ireq_q, balance_o, protection_output_function_o, stage_q};
				ccp_pkg::OFS_IRQ_ST: rdata_q <= {27'h0, irq_st_q};
				ccp_pkg::OFS_IRQ_MASK: rdata_q <= {27'h0, irq_mask_q};
				ccp_pkg::OFS_OV_CNT: rdata_q <= {16'h0, ov_cnt_q};
				ccp_pkg::OFS_UV_CNT: rdata_q <= {16'h0, uv_cnt_q};
				ccp_pkg::OFS_ERR: rdata_q <= {28'h0, err_q};
				ccp_pkg::OFS_CELLMM: rdata_q <= {vhi, vlo};
				default: rdata_q <= 32'h0000_0000; // Unmapped reads zero
			endcase
		end
	end
	assign avs_readdata_o = rdata_q;

	// Charger command and references
	assign charger_o.enable = charging & (ireq_q != '0);
	assign charger_o.current = ireq_q;
	assign charge_done_o = (stage_q == ccp_pkg::CCP_DONE);
	assign soc_full_ref_o = vfull_q;
	assign soc_empty_ref_o = vempty_q;
endmodule

// >>> include/ccp_pkg.sv
// Package for the cell charge protection control block: map, fields, types
package ccp_pkg;
	// Widths
	localparam int VW = 16; // Cell voltage in mV
	localparam int IW = 16; // Current in units of 0.1 A
	localparam int NCELL = 8;
	localparam int CIW = 3;
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_VMAX = 8'h04;
	localparam logic [7:0] OFS_VFULL = 8'h08;
	localparam logic [7:0] OFS_DISB = 8'h0C;
	localparam logic [7:0] OFS_EBAL = 8'h10;
	localparam logic [7:0] OFS_BRNG = 8'h14;
	localparam logic [7:0] OFS_VRST = 8'h18;
	localparam logic [7:0] OFS_VPRE = 8'h1C;
	localparam logic [7:0] OFS_VEMPTY = 8'h20;
	localparam logic [7:0] OFS_VMIN = 8'h24;
	localparam logic [7:0] OFS_IFAST = 8'h28;
	localparam logic [7:0] OFS_ISLOW = 8'h2C;
	localparam logic [7:0] OFS_PFIN = 8'h30;
	localparam logic [7:0] OFS_PPRE = 8'h34;
	localparam logic [7:0] OFS_STATUS = 8'h38;
	localparam logic [7:0] OFS_IRQ_ST = 8'h3C;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h40;
	localparam logic [7:0] OFS_OV_CNT = 8'h44;
	localparam logic [7:0] OFS_UV_CNT = 8'h48;
	localparam logic [7:0] OFS_ERR = 8'h4C;
	localparam logic [7:0] OFS_CELLMM = 8'h50;
	// Control fields
	localparam int CTRL_OV_EN = 0;
	localparam int CTRL_UV_EN = 1;
	localparam int CTRL_CMD_CHG = 2; // Charger accepts current commands
	// Interrupt bits
	localparam int IRQ_OV = 0;
	localparam int IRQ_UV = 1;
	localparam int IRQ_ABORT = 2;
	localparam int IRQ_FINISH = 3;
	localparam int IRQ_DISB = 4;
	localparam int IRQ_W = 5;
	// Error codes
	localparam logic [3:0] ERR_NONE = 4'h0;
	localparam logic [3:0] ERR_OV = 4'h1;
	localparam logic [3:0] ERR_UV = 4'h2;
	// Reset values of configuration
	localparam logic [VW-1:0] RST_VMAX = 16'h1068; // 4200 mV
	localparam logic [VW-1:0] RST_VFULL = 16'h1004; // 4100 mV
	localparam logic [VW-1:0] RST_DISB = 16'h0032; // 50 mV
	localparam logic [VW-1:0] RST_EBAL = 16'h0F3C; // 3900 mV
	localparam logic [VW-1:0] RST_BRNG = 16'h0032;
	localparam logic [VW-1:0] RST_VRST = 16'h0F3C;
	localparam logic [VW-1:0] RST_VPRE = 16'h07D0; // 2000 mV, pre-charge off
	localparam logic [VW-1:0] RST_VEMPTY = 16'h0C80;
	localparam logic [VW-1:0] RST_VMIN = 16'h0BB8;
	localparam logic [IW-1:0] RST_IFAST = 16'h00C8;
	localparam logic [IW-1:0] RST_ISLOW = 16'h0064;
	localparam logic [7:0] RST_PFIN = 8'h0A;
	localparam logic [7:0] RST_PPRE = 8'h14;
	localparam logic [7:0] PCT_FULL = 8'h64;
	// Current ramp step, cycles between ramp steps
	localparam logic [IW-1:0] RAMP_STEP = 16'h0001;
	localparam logic [15:0] RAMP_DIV = 16'h03E8;
	// Charge stages
	typedef enum logic [2:0] {
		CCP_IDLE, CCP_PRE, CCP_MAIN, CCP_EARLY, CCP_BAL_DOWN, CCP_BAL_UP, CCP_RAMP, CCP_DONE
	} ccp_stage_t;
	// Avalon request
	typedef struct packed {
		logic read;
		logic write;
		logic [7:0] address;
		logic [31:0] writedata;
	} ccp_av_req_t;
	// Charger request
	typedef struct packed {
		logic enable;
		logic [IW-1:0] current;
	} ccp_chg_t;
endpackage

// >>> dv/ccp_sva.sv
// Port checker for the cell charge protection control block
module ccp_sva (
	// Clock, reset, enable
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Register bus
	input wire logic [7:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic avs_waitrequest_o,
	// Cells, charger, protection
	input wire logic [ccp_pkg::NCELL*ccp_pkg::VW-1:0] cell_mv_i,
	input wire logic charger_present_i,
	input wire ccp_pkg::ccp_chg_t charger_o,
	input wire logic balance_o,
	input wire logic charge_done_o,
	input wire logic protection_output_function_o,
	input wire logic [ccp_pkg::VW-1:0] soc_full_ref_o
);
	logic [1:0] en_q;
	logic [15:0] vmax_q, vmin_q, disb_q, hi, lo;
	wire take = avs_write_i && !avs_waitrequest_o;
	// Shadow thresholds, written at the answering edge like the design
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			en_q <= 2'h3;
			vmax_q <= ccp_pkg::RST_VMAX;
			vmin_q <= ccp_pkg::RST_VMIN;
			disb_q <= ccp_pkg::RST_DISB;
		end else if (take) begin
			if (avs_address_i == ccp_pkg::OFS_CTRL) en_q <= avs_writedata_i[1:0];
			if (avs_address_i == ccp_pkg::OFS_VMAX) vmax_q <= avs_writedata_i[15:0];
			if (avs_address_i == ccp_pkg::OFS_VMIN) vmin_q <= avs_writedata_i[15:0];
			if (avs_address_i == ccp_pkg::OFS_DISB) disb_q <= avs_writedata_i[15:0];
		end
	end
	// Highest and lowest cell
	always_comb begin
		hi = 16'h0000;
		lo = 16'hFFFF;
		for (int c = 0; c < ccp_pkg::NCELL; c++) begin
			if (cell_mv_i[ccp_pkg::VW*c +: ccp_pkg::VW] > hi) hi = cell_mv_i[ccp_pkg::VW*c +: ccp_pkg::VW];
			if (cell_mv_i[ccp_pkg::VW*c +: ccp_pkg::VW] < lo) lo = cell_mv_i[ccp_pkg::VW*c +: ccp_pkg::VW];
		end
	end
	wire viol = (en_q[0] && hi > vmax_q) || (en_q[1] && lo < vmin_q);
	wire wide = (hi - lo) > disb_q;
	a_prot_follow: assert property (@(posedge clock_i) disable iff (rst_i)
		!$past(rst_i) |-> protection_output_function_o == $past(viol)) else $error("protect output mismatch");
	a_bal_follow: assert property (@(posedge clock_i) disable iff (rst_i)
		!$past(rst_i) |-> balance_o == $past(wide)) else $error("balance flag mismatch");
	a_wait_first: assert property (@(posedge clock_i) disable iff (rst_i)
		$rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o) else $error("no wait in first cycle");
	a_wait_one: assert property (@(posedge clock_i) disable iff (rst_i)
		(avs_read_i || avs_write_i) && avs_waitrequest_o && ce_i |=> !avs_waitrequest_o) else $error("late answer");
	a_unmapped_zero: assert property (@(posedge clock_i) disable iff (rst_i)
		avs_read_i && !avs_waitrequest_o && avs_address_i > 8'h50 |-> avs_readdata_o == 32'h0)
		else $error("unmapped read not zero");
	a_done_stops: assert property (@(posedge clock_i) disable iff (rst_i)
		charge_done_o |-> !charger_o.enable) else $error("charging while done");
	a_absent_off: assert property (@(posedge clock_i) disable iff (rst_i)
		!charger_present_i [*2] |-> !charger_o.enable) else $error("charging without charger");
	a_enable_cur: assert property (@(posedge clock_i) disable iff (rst_i)
		charger_o.enable |-> charger_o.current != 16'h0000) else $error("enable with zero current");
	a_ref_hold: assert property (@(posedge clock_i) disable iff (rst_i)
		!$stable(soc_full_ref_o) |-> $past(avs_write_i) && $past(avs_address_i) == ccp_pkg::OFS_VFULL)
		else $error("full reference moved without write");
endmodule
bind ccp_top ccp_sva u_sva (.clock_i(clock_i), .rst_i(rst_i), .ce_i(ce_i), .avs_address_i(avs_address_i),
	.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
	.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .cell_mv_i(cell_mv_i),
	.charger_present_i(charger_present_i), .charger_o(charger_o), .balance_o(balance_o),
	.charge_done_o(charge_done_o), .protection_output_function_o(protection_output_function_o),
	.soc_full_ref_o(soc_full_ref_o));

// >>> dv/ccp_pack_model.sv
// Behavioural model of the cells and the charger seen by the block
module ccp_pack_model (
	// Cell measurements
	output logic [ccp_pkg::NCELL*ccp_pkg::VW-1:0] cell_mv_o,
	// Charger presence and rate select
	output logic charger_present_o,
	output logic fast_charge_select_function_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Balanced mid-range pack, charger unplugged
	initial begin
		cell_mv_o = {ccp_pkg::NCELL{16'h0E74}};
		charger_present_o = 1'b0;
		fast_charge_select_function_o = 1'b1;
	end
	// Called just after a rising edge, so changes land off the sampling edge
	task set_cell(input int i, input logic [15:0] mv);
		cell_mv_o[ccp_pkg::VW*i +: ccp_pkg::VW] <= mv;
	endtask
	task set_chg(input logic p, input logic f);
		charger_present_o <= p;
		fast_charge_select_function_o <= f;
	endtask
endmodule

// >>> dv/ccp_tb_top.sv
// Self-checking testbench for the cell charge protection control block
module ccp_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock_i, rst_i, ce_i, rd, wr, wreq, pres, fast, bal, done, prot, irq;
	logic [7:0] addr;
	logic [31:0] wdata, rdata, d;
	logic [3:0] be;
	logic [ccp_pkg::NCELL*ccp_pkg::VW-1:0] cells;
	logic [15:0] full_ref, empty_ref;
	ccp_pkg::ccp_chg_t chg;
	int error_cnt = 0;
	int n_tests = 0;
	int cyc = 0;
	int seed = 2;
	int cv[8] = '{default: 16'h0E74};
	ccp_top dut (.clock_i(clock_i), .rst_i(rst_i), .ce_i(ce_i), .avs_address_i(addr), .avs_read_i(rd),
		.avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be), .avs_readdata_o(rdata),
		.avs_waitrequest_o(wreq), .cell_mv_i(cells), .charger_present_i(pres), .fast_charge_select_function_i(fast),
		.charger_o(chg), .balance_o(bal), .charge_done_o(done), .protection_output_function_o(prot),
		.soc_full_ref_o(full_ref), .soc_empty_ref_o(empty_ref), .irq_o(irq));
	ccp_pack_model pack (.cell_mv_o(cells), .charger_present_o(pres), .fast_charge_select_function_o(fast));
	// Clock
	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end
	// Hang guard, well above the length of the sequence
	always @(posedge clock_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			end_sim();
		end
	end
	task end_sim();
		$display("tests %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task chk_w(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task chk_b(input logic g, input logic e);
		chk_w({31'h0, g}, {31'h0, e});
	endtask
	// One bus access; holds the request until waitrequest is seen low
	task av(input logic w, input logic [7:0] a, input logic [31:0] v);
		@(posedge clock_i);
		rd <= !w;
		wr <= w;
		addr <= a;
		wdata <= v;
		@(posedge clock_i);
		while (wreq !== 1'b0) @(posedge clock_i);
		d = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task rd_chk(input logic [7:0] a, input logic [31:0] e);
		av(1'b0, a, 32'h0);
		chk_w(d, e);
	endtask
	task set(input int i, input int mv);
		cv[i] = mv;
		pack.set_cell(i, 16'(mv));
	endtask
	function automatic int gap();
		int hi, lo;
		hi = 0;
		lo = 65535;
		foreach (cv[i]) begin
			if (cv[i] > hi) hi = cv[i];
			if (cv[i] < lo) lo = cv[i];
		end
		return hi - lo;
	endfunction
	// Current request settles after a stage change of unstated length
	task wait_cur(input int e);
		int k;
		k = 0;
		while (chg.current !== 16'(e) && k < 100) begin
			@(posedge clock_i);
			k++;
		end
		chk_w({16'h0, chg.current}, e);
	endtask
	// Protection check: output is registered one cycle after the cells
	task prot_is(input int i, input int mv, input logic e);
		set(i, mv);
		repeat (2) @(posedge clock_i);
		chk_b(prot, e);
	endtask
	initial begin
		{rst_i, ce_i, be} = {1'b1, 1'b1, 4'hF};
		{addr, rd, wr, wdata} = '0;
		repeat (16) @(posedge clock_i);
		rst_i <= 1'b0;
		chk_w({16'h0, full_ref}, {16'h0, ccp_pkg::RST_VFULL});
		chk_w({16'h0, empty_ref}, {16'h0, ccp_pkg::RST_VEMPTY});
		rd_chk(ccp_pkg::OFS_CTRL, 32'h0000_0003);
		rd_chk(ccp_pkg::OFS_VPRE, {16'h0, ccp_pkg::RST_VPRE});
		rd_chk(8'h54, 32'h0);
		av(1'b1, ccp_pkg::OFS_IRQ_MASK, 32'h0000_001F);
		prot_is(3, 16'h1069, 1'b1);
		chk_b(irq, 1'b1);
		prot_is(3, 16'h1068, 1'b0);
		rd_chk(ccp_pkg::OFS_OV_CNT, 32'h1);
		rd_chk(ccp_pkg::OFS_IRQ_ST, 32'h11);
		prot_is(3, 16'h0E74, 1'b0);
		av(1'b1, ccp_pkg::OFS_IRQ_ST, 32'h1F);
		@(posedge clock_i);
		chk_b(irq, 1'b0);
		av(1'b1, ccp_pkg::OFS_CTRL, 32'h2);
		prot_is(3, 16'h10CC, 1'b0);
		prot_is(3, 16'h0E74, 1'b0);
		av(1'b1, ccp_pkg::OFS_CTRL, 32'h7);
		prot_is(5, 16'h0BB7, 1'b1);
		rd_chk(ccp_pkg::OFS_UV_CNT, 32'h1);
		prot_is(5, 16'h0E74, 1'b0);
		// Random spreads straddling the programmed disbalance
		for (int p = 0; p < 2; p++) begin
			av(1'b1, ccp_pkg::OFS_DISB, p ? 32'h10 : 32'h32);
			repeat (12) begin
				foreach (cv[i]) set(i, 16'h0DAC + ($random(seed) & (p ? 31 : 63)));
				repeat (2) @(posedge clock_i);
				chk_b(bal, gap() > (p ? 16 : 50));
			end
		end
		foreach (cv[i]) set(i, 16'h0E74);
		av(1'b1, ccp_pkg::OFS_IRQ_ST, 32'h1F);
		// Pre-charge, then main stage at both rates
		av(1'b1, ccp_pkg::OFS_VPRE, 32'h0ED8);
		pack.set_chg(1'b1, 1'b1);
		wait_cur(int'(ccp_pkg::RST_IFAST) * int'(ccp_pkg::RST_PPRE) / int'(ccp_pkg::PCT_FULL));
		pack.set_chg(1'b1, 1'b0);
		wait_cur(int'(ccp_pkg::RST_ISLOW) * int'(ccp_pkg::RST_PPRE) / int'(ccp_pkg::PCT_FULL));
		av(1'b1, ccp_pkg::OFS_VPRE, 32'h07D0);
		wait_cur(int'(ccp_pkg::RST_ISLOW));
		pack.set_chg(1'b1, 1'b1);
		wait_cur(int'(ccp_pkg::RST_IFAST));
		chk_b(chg.enable, 1'b1);
		// Spread above the early threshold while in the main stage
		set(1, 16'h0F6E);
		@(posedge clock_i);
		av(1'b0, ccp_pkg::OFS_STATUS, 32'h0);
		chk_w(d & 32'h7, {29'h0, ccp_pkg::CCP_EARLY});
		set(1, 16'h0E74);
		// Abort on a limit violation while charging, then restart
		set(0, 16'h109A);
		repeat (50) if (done !== 1'b1) @(posedge clock_i);
		chk_b(done, 1'b1);
		rd_chk(ccp_pkg::OFS_ERR, {28'h0, ccp_pkg::ERR_OV});
		av(1'b0, ccp_pkg::OFS_IRQ_ST, 32'h0);
		chk_w(d & 32'h5, 32'h5);
		set(0, 16'h0E74);
		repeat (50) if (done !== 1'b0) @(posedge clock_i);
		chk_b(done, 1'b0);
		wait_cur(int'(ccp_pkg::RST_IFAST));
		pack.set_chg(1'b0, 1'b1);
		repeat (3) @(posedge clock_i);
		chk_b(chg.enable, 1'b0);
		// Commandable charger: small nominal so the slow ramp ends quickly
		av(1'b1, ccp_pkg::OFS_IFAST, 32'h0A);
		av(1'b1, ccp_pkg::OFS_PFIN, 32'h32);
		foreach (cv[i]) set(i, int'(ccp_pkg::RST_VFULL));
		pack.set_chg(1'b1, 1'b1);
		wait_cur(10);
		repeat (1100) @(posedge clock_i);
		chk_w({16'h0, chg.current}, 10 - int'(ccp_pkg::RAMP_STEP));
		repeat (6000) if (done !== 1'b1) @(posedge clock_i);
		chk_w({16'h0, chg.current}, 10 * 50 / int'(ccp_pkg::PCT_FULL));
		chk_b(done, 1'b1);
		av(1'b0, ccp_pkg::OFS_IRQ_ST, 32'h0);
		chk_w(d & 32'h8, 32'h8);
		// Plain charger: balance down, recharge inside the range, then done
		pack.set_chg(1'b0, 1'b1);
		av(1'b1, ccp_pkg::OFS_CTRL, 32'h3);
		foreach (cv[i]) set(i, i ? 16'h0FA0 : int'(ccp_pkg::RST_VFULL));
		pack.set_chg(1'b1, 1'b1);
		repeat (5) @(posedge clock_i);
		chk_w({16'h0, chg.current}, 0);
		chk_b(done, 1'b0);
		set(0, int'(ccp_pkg::RST_VFULL) - int'(ccp_pkg::RST_BRNG) - 1);
		wait_cur(10);
		foreach (cv[i]) set(i, int'(ccp_pkg::RST_VFULL));
		repeat (5) @(posedge clock_i);
		chk_b(done, 1'b1);
		av(1'b1, ccp_pkg::OFS_VFULL, 32'h1036);
		@(posedge clock_i);
		chk_w({16'h0, full_ref}, 32'h1036);
		end_sim();
	end
endmodule
